// ==== adcrc_pkg.sv ====
package adcrc_pkg;

    // ********************************************************
    // register indices (byte address = 4 * index)
    // ********************************************************
    localparam logic [9:0] ADCRC_IDX_PRIM_HIGH = 10'h000; // primary high
    localparam logic [9:0] ADCRC_IDX_PRIM_LOW  = 10'h001; // primary low
    localparam logic [9:0] ADCRC_IDX_SEC_HIGH  = 10'h002; // secondary high
    localparam logic [9:0] ADCRC_IDX_SEC_LOW   = 10'h003; // secondary low
    localparam logic [9:0] ADCRC_IDX_CFG_FIRST = 10'h004; // first config
    localparam logic [9:0] ADCRC_IDX_CFG_SEC   = 10'h005; // second config
    localparam logic [9:0] ADCRC_IDX_CAL_PTR   = 10'h006; // calib pointer
    localparam logic [9:0] ADCRC_IDX_CAL_PORT  = 10'h007; // coeff port
    localparam logic [9:0] ADCRC_IDX_REF_FIRST = 10'h0D1; // bias/ref first
    localparam logic [9:0] ADCRC_IDX_REF_SEC   = 10'h0D9; // bias/ref second

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int ADCRC_CFG_LIN  = 0; // linearity_cal_start
    localparam int ADCRC_CFG_OFF  = 1; // offset_cal_start
    localparam int ADCRC_CFG_GAIN = 2; // gain_cal_start
    localparam int ADCRC_CFG_SRC  = 3; // cal_source_select
    localparam int ADCRC_CFG_DIFF = 4; // differential mode, first only
    localparam int ADCRC_PTR_INC  = 7; // pointer_autoinc
    localparam int ADCRC_PTR_BANK = 6; // coeff_bank_select
    localparam int ADCRC_REF_BIAS = 1; // bias generator enable
    localparam int ADCRC_REF_BUF  = 0; // reference buffer enable

    // ********************************************************
    // reset values and coefficient map
    // ********************************************************
    localparam logic [7:0] ADCRC_PTR_RESET = 8'hD7; // pointer reset
    localparam logic [7:0] ADCRC_REF_RESET = 8'h00; // bias/ref reset
    localparam logic [7:0] ADCRC_CFG_RESET = 8'h00; // config reset
    localparam logic [5:0] ADCRC_LIN_LAST  = 6'h12; // last linearity
    localparam logic [5:0] ADCRC_OFF_LOW   = 6'h13; // offset low byte
    localparam logic [5:0] ADCRC_OFF_HIGH  = 6'h14; // offset high byte
    localparam logic [5:0] ADCRC_GAIN_LOW  = 6'h15; // gain low byte
    localparam logic [5:0] ADCRC_GAIN_HIGH = 6'h16; // gain high byte
    localparam int         ADCRC_NCOEF     = 23;    // bytes per bank

    // apb handshake phase, gray coded
    typedef enum logic [1:0]
    {
        ADCRC_PH_IDLE = 2'b00,
        ADCRC_PH_ACK  = 2'b01
    } adcrc_phase_t;

    // writable bits of each coefficient byte
    function automatic logic [7:0] adcrc_coef_mask(input logic [5:0] idx);
        logic [7:0] m;
        m = 8'h00;
        if (idx <= ADCRC_LIN_LAST || idx == ADCRC_OFF_LOW ||
            idx == ADCRC_GAIN_LOW)
            m = 8'hFF;
        else if (idx == ADCRC_OFF_HIGH)
            m = 8'h3F;
        else if (idx == ADCRC_GAIN_HIGH)
            m = 8'h1F;
        return m;
    endfunction : adcrc_coef_mask

endpackage : adcrc_pkg

// ==== adcrc_cal_seq.sv ====
`timescale 1ns/100ps
`default_nettype none
// per-converter calibration start bits and source select
module adcrc_cal_seq
    import adcrc_pkg::*;
(
    input  wire logic       pclk,      // system clock
    input  wire logic       presetn,   // async reset, active low
    input  wire logic       cfg_wr,    // config write strobe
    input  wire logic [7:0] cfg_wdata, // config write data
    input  wire logic [2:0] cal_done,  // finish pulses lin/off/gain
    output logic      [2:0] cal_run,   // start bits to the core
    output logic            cal_src    // source select
);

    // state of this sequencer
    typedef struct packed {
        logic [2:0] run; // start bits
        logic       src; // source select
    } adcrc_seq_t;

    adcrc_seq_t s_reg;  // registered state
    adcrc_seq_t s_next; // next state

    // ********************************************************
    // next state
    // ********************************************************
    always_comb
    begin
        s_next = s_reg;
        // finished calibrations drop their start bit
        s_next.run = s_reg.run & ~cal_done; // R9
        if (cfg_wr)
        begin
            // a one written starts the run; set beats finish
            s_next.run = s_next.run | cfg_wdata[ADCRC_CFG_GAIN:0]; // R6
            s_next.src = cfg_wdata[ADCRC_CFG_SRC]; // R10
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign cal_run = s_reg.run; // R5
    assign cal_src = s_reg.src;

endmodule : adcrc_cal_seq
`default_nettype wire

// ==== adcrc_top.sv ====
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R1] single-ended results are straight binary
// [R2] differential result is halved signed difference
// [R3] differential result lands in primary registers
// [R4] secondary registers always hold its own result
// [R5] each converter calibrates independently
// [R6] software start bit launches each calibration
// [R7] coefficient port reaches byte at pointer index
// [R8] linearity, offset, gain bytes at fixed locations
// [R9] hardware clears start bit when finished
// [R10] source bit picks internal or external voltages
// [R11] bank bit picks which converter's coefficients
// [R12] auto-increment advances index after port access
module adcrc_top
    import adcrc_pkg::*;
(
    input  wire logic        pclk,           // system clock
    input  wire logic        presetn,        // async reset
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb enable
    input  wire logic        pwrite,         // apb direction
    input  wire logic [11:0] paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    output logic      [31:0] prdata,         // apb read data
    output logic             pready,         // apb ready
    output logic             pslverr,        // apb error
    input  wire logic        prim_valid,     // primary result strobe
    input  wire logic [15:0] prim_data,      // primary raw code
    input  wire logic        sec_valid,      // secondary result strobe
    input  wire logic [15:0] sec_data,       // secondary raw code
    input  wire logic [2:0]  cal_done_first, // first cal finished
    input  wire logic [2:0]  cal_done_sec,   // second cal finished
    output logic      [2:0]  cal_run_first,  // first cal running
    output logic      [2:0]  cal_run_sec,    // second cal running
    output logic             cal_src_first,  // first cal source
    output logic             cal_src_sec,    // second cal source
    output logic             diff_mode,      // differential mode
    output logic             bias_gen_on_first,
    output logic             ref_buffer_on_first,
    output logic             bias_gen_on_second,
    output logic             ref_buffer_on_second,
    output logic      [13:0] offset_first,   // first offset value
    output logic      [12:0] gain_first,     // first gain value
    output logic      [13:0] offset_second,  // second offset value
    output logic      [12:0] gain_second     // second gain value
);

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        adcrc_phase_t                     phase;   // apb phase
        logic [31:0]                      rdata;   // read data
        logic                             ready;   // ready flop
        logic                             slverr;  // error flop
        logic [15:0]                      prim;    // primary result
        logic [15:0]                      sec;     // secondary result
        logic                             diff;    // differential
        logic [7:0]                       ref0;    // bias/ref first
        logic [7:0]                       ref1;    // bias/ref second
        logic [7:0]                       ptr;     // calib pointer
        logic [1:0][ADCRC_NCOEF-1:0][7:0] coef;    // two banks
    } adcrc_state_t;

    adcrc_state_t r_reg;   // registered state
    adcrc_state_t r_next;  // next state

    logic [9:0]  idx;      // word index of the access
    logic        wr_done;  // write completes this edge
    logic        acc_done; // any access completes this edge
    logic        cfg0_wr;  // first config written
    logic        cfg1_wr;  // second config written
    logic [2:0]  run0;     // first start bits
    logic [2:0]  run1;     // second start bits
    logic        src0;     // first source bit
    logic        src1;     // second source bit
    logic [16:0] dsum;     // signed difference, one extra bit
    logic        bank;     // selected coefficient bank
    logic [5:0]  cidx;     // selected coefficient index
    logic        cvalid;   // index maps to a stored byte

    assign idx      = paddr[11:2];
    assign acc_done = psel && penable && r_reg.ready;
    assign wr_done  = acc_done && pwrite;
    assign cfg0_wr  = wr_done && idx == ADCRC_IDX_CFG_FIRST;
    assign cfg1_wr  = wr_done && idx == ADCRC_IDX_CFG_SEC;
    assign dsum     = {1'b0, prim_data} - {1'b0, sec_data};
    assign bank     = r_reg.ptr[ADCRC_PTR_BANK]; // R11
    assign cidx     = r_reg.ptr[5:0]; // R7
    assign cvalid   = cidx <= ADCRC_GAIN_HIGH;

    // ********************************************************
    // calibration sequencers, one per converter
    // ********************************************************
    adcrc_cal_seq u_seq_first
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .cfg_wr    (cfg0_wr),
        .cfg_wdata (pwdata[7:0]),
        .cal_done  (cal_done_first),
        .cal_run   (run0),
        .cal_src   (src0)
    );

    adcrc_cal_seq u_seq_sec
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .cfg_wr    (cfg1_wr),
        .cfg_wdata (pwdata[7:0]),
        .cal_done  (cal_done_sec),
        .cal_run   (run1),
        .cal_src   (src1)
    );

    // ********************************************************
    // next state
    // ********************************************************
    always_comb
    begin
        r_next = r_reg;
        r_next.ready  = 1'b0;
        r_next.slverr = 1'b0;
        r_next.phase  = ADCRC_PH_IDLE;
        // setup phase: decode and capture the answer
        if (psel && !penable)
        begin
            r_next.phase = ADCRC_PH_ACK;
            r_next.ready = 1'b1;
            r_next.rdata = '0;
            case (idx)
                ADCRC_IDX_PRIM_HIGH: r_next.rdata[7:0] = r_reg.prim[15:8];
                ADCRC_IDX_PRIM_LOW:  r_next.rdata[7:0] = r_reg.prim[7:0];
                ADCRC_IDX_SEC_HIGH:  r_next.rdata[7:0] = r_reg.sec[15:8];
                ADCRC_IDX_SEC_LOW:   r_next.rdata[7:0] = r_reg.sec[7:0];
                ADCRC_IDX_CFG_FIRST: r_next.rdata[7:0] =
                    {3'b000, r_reg.diff, src0, run0};
                ADCRC_IDX_CFG_SEC:   r_next.rdata[7:0] =
                    {4'h0, src1, run1};
                ADCRC_IDX_CAL_PTR:   r_next.rdata[7:0] = r_reg.ptr;
                ADCRC_IDX_CAL_PORT:  // unmapped bytes read zero
                    if (cvalid)
                        r_next.rdata[7:0] = r_reg.coef[bank][cidx]; // R7
                ADCRC_IDX_REF_FIRST: r_next.rdata[7:0] = r_reg.ref0;
                ADCRC_IDX_REF_SEC:   r_next.rdata[7:0] = r_reg.ref1;
                default:             r_next.slverr = 1'b1;
            endcase
        end
        // access completes: writes take effect
        if (wr_done)
        begin
            case (idx)
                ADCRC_IDX_CFG_FIRST:
                    r_next.diff = pwdata[ADCRC_CFG_DIFF];
                ADCRC_IDX_CAL_PTR:   r_next.ptr  = pwdata[7:0];
                ADCRC_IDX_CAL_PORT:  // masked to the field widths
                    if (cvalid)
                        r_next.coef[bank][cidx] = pwdata[7:0] &
                            adcrc_coef_mask(cidx); // R8
                ADCRC_IDX_REF_FIRST: r_next.ref0 = pwdata[7:0] & 8'h03;
                ADCRC_IDX_REF_SEC:   r_next.ref1 = pwdata[7:0] & 8'h03;
                default:             ;
            endcase
        end
        // auto-increment after any port access
        if (acc_done && idx == ADCRC_IDX_CAL_PORT &&
            r_reg.ptr[ADCRC_PTR_INC])
            r_next.ptr[5:0] = r_reg.ptr[5:0] + 6'h01; // R12
        // result capture
        if (prim_valid)
        begin
            if (r_reg.diff)
                r_next.prim = dsum[16:1]; // R2 R3
            else
                r_next.prim = prim_data; // R1
        end
        if (sec_valid)
            r_next.sec = sec_data; // R4
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_reg       <= '0;
            r_reg.ptr   <= ADCRC_PTR_RESET;
            r_reg.ref0  <= ADCRC_REF_RESET;
            r_reg.ref1  <= ADCRC_REF_RESET;
        end
        else
            r_reg <= r_next;
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign prdata               = r_reg.rdata;
    assign pready               = r_reg.ready;
    assign pslverr              = r_reg.slverr;
    assign cal_run_first        = run0;
    assign cal_run_sec          = run1;
    assign cal_src_first        = src0;
    assign cal_src_sec          = src1;
    assign diff_mode            = r_reg.diff;
    assign bias_gen_on_first    = r_reg.ref0[ADCRC_REF_BIAS];
    assign ref_buffer_on_first  = r_reg.ref0[ADCRC_REF_BUF];
    assign bias_gen_on_second   = r_reg.ref1[ADCRC_REF_BIAS];
    assign ref_buffer_on_second = r_reg.ref1[ADCRC_REF_BUF];
    assign offset_first  = {r_reg.coef[0][ADCRC_OFF_HIGH][5:0],
                            r_reg.coef[0][ADCRC_OFF_LOW]};
    assign gain_first    = {r_reg.coef[0][ADCRC_GAIN_HIGH][4:0],
                            r_reg.coef[0][ADCRC_GAIN_LOW]};
    assign offset_second = {r_reg.coef[1][ADCRC_OFF_HIGH][5:0],
                            r_reg.coef[1][ADCRC_OFF_LOW]};
    assign gain_second   = {r_reg.coef[1][ADCRC_GAIN_HIGH][4:0],
                            r_reg.coef[1][ADCRC_GAIN_LOW]};

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_single_ended_pass: assert property ( // R1
        prim_valid && !r_reg.diff |=> r_reg.prim == $past(prim_data))
        else $error("single-ended result not straight binary");

    chk_diff_halved: assert property ( // R2
        prim_valid && r_reg.diff && prim_data == 16'hFFFF &&
        sec_data == 16'h0000 |=> r_reg.prim == 16'h7FFF)
        else $error("differential full scale wrong");

    chk_diff_primary: assert property ( // R3
        prim_valid && r_reg.diff |=>
        r_reg.prim == $past(dsum[16:1]))
        else $error("differential result not in primary");

    chk_sec_own: assert property ( // R4
        sec_valid |=> r_reg.sec == $past(sec_data))
        else $error("secondary result not its own");

    chk_indep_cal: assert property ( // R5
        cfg0_wr && !cfg1_wr && cal_done_sec == 3'b000 |=>
        run1 == $past(run1))
        else $error("second calibration disturbed");

    chk_start_set: assert property ( // R6
        cfg0_wr && pwdata[ADCRC_CFG_OFF] |=> run0[ADCRC_CFG_OFF])
        else $error("offset start not set");

    chk_port_read: assert property ( // R7
        psel && !penable && !pwrite && idx == ADCRC_IDX_CAL_PORT &&
        cvalid |=> prdata[7:0] == $past(r_reg.coef[bank][cidx]))
        else $error("coefficient read wrong byte");

    chk_gain_width: assert property ( // R8
        r_reg.coef[0][ADCRC_GAIN_HIGH][7:5] == 3'b000 &&
        r_reg.coef[1][ADCRC_OFF_HIGH][7:6] == 2'b00)
        else $error("coefficient field too wide");

    chk_done_clears: assert property ( // R9
        cal_done_first[0] && !cfg0_wr |=> !run0[0])
        else $error("start bit not cleared");

    chk_src_sel: assert property ( // R10
        cfg1_wr |=> src1 == $past(pwdata[ADCRC_CFG_SRC]))
        else $error("source select not taken");

    chk_bank_write: assert property ( // R11
        wr_done && idx == ADCRC_IDX_CAL_PORT && bank &&
        cidx == ADCRC_OFF_LOW |=>
        offset_second[7:0] == $past(pwdata[7:0]))
        else $error("bank select not honoured");

    chk_autoinc: assert property ( // R12
        acc_done && idx == ADCRC_IDX_CAL_PORT && r_reg.ptr[7] |=>
        r_reg.ptr[5:0] == $past(r_reg.ptr[5:0]) + 6'h01)
        else $error("pointer did not advance");

    cov_diff_result: cover property (prim_valid && r_reg.diff);
    cov_cal_finish:  cover property (run0[2] ##1 !run0[2]);
    cov_inc_read:    cover property (acc_done && !pwrite &&
                                     idx == ADCRC_IDX_CAL_PORT &&
                                     r_reg.ptr[7]);

endmodule : adcrc_top
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb
    import adcrc_pkg::*;
;
    // ********************************************************
    // stimulus, observed outputs and bookkeeping
    // ********************************************************
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;          // apb byte address
    logic [31:0] pwdata, prdata; // apb data
    logic        pready, pslverr;
    logic        prim_valid, sec_valid;
    logic [15:0] prim_data, sec_data;
    logic [2:0]  cal_done_first, cal_done_sec, cal_run_first, cal_run_sec;
    logic        cal_src_first, cal_src_sec, diff_mode;
    logic        bias_gen_on_first, ref_buffer_on_first;
    logic        bias_gen_on_second, ref_buffer_on_second;
    logic [13:0] offset_first, offset_second;
    logic [12:0] gain_first, gain_second;
    int          n_mismatch, total_checks;
    logic [31:0] rd;             // last read data
    logic        er;             // last error flag
    logic [7:0]  cexp [2][24];   // expected coefficient bytes

    adcrc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prim_valid(prim_valid),
        .prim_data(prim_data), .sec_valid(sec_valid),
        .sec_data(sec_data), .cal_done_first(cal_done_first),
        .cal_done_sec(cal_done_sec), .cal_run_first(cal_run_first),
        .cal_run_sec(cal_run_sec), .cal_src_first(cal_src_first),
        .cal_src_sec(cal_src_sec), .diff_mode(diff_mode),
        .bias_gen_on_first(bias_gen_on_first),
        .ref_buffer_on_first(ref_buffer_on_first),
        .bias_gen_on_second(bias_gen_on_second),
        .ref_buffer_on_second(ref_buffer_on_second),
        .offset_first(offset_first), .gain_first(gain_first),
        .offset_second(offset_second), .gain_second(gain_second));

    // free running 25 mhz clock
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ********************************************************
    // tasks and expectation functions
    // ********************************************************
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready seen high
    task automatic apb(input logic wr, input logic [9:0] idx,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // pready, prdata and pslverr are taken at the rising edge
        do
        begin
            @(posedge pclk);
            n++;
            if (n > 16)
            begin
                n_mismatch++;
                $display("[ERR] %0t pready never came", $time);
                end_sim;
            end
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // let the access edge settle before outputs are looked at
        @(negedge pclk);
    endtask : apb

    // read one register and compare its byte
    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e,
                          input string m);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h000000, e}, m);
    endtask : rd_chk

    // combined code: halved difference of the two raw codes
    function automatic logic [15:0] diff_code(input logic [15:0] p, s);
        logic [16:0] t;
        t = {1'b0, p} - {1'b0, s};
        return t[16:1];
    endfunction : diff_code

    // bits that a coefficient byte keeps
    function automatic logic [7:0] keep(input logic [5:0] i);
        if (i <= 6'h12 || i == 6'h13 || i == 6'h15)
            return 8'hFF;
        if (i == 6'h14)
            return 8'h3F;
        if (i == 6'h16)
            return 8'h1F;
        return 8'h00;
    endfunction : keep

    // present both results, then read the four result registers
    task automatic check_res(input logic [15:0] p, s, input logic dm);
        logic [15:0] e;
        e = dm ? diff_code(p, s) : p;
        @(posedge pclk);
        prim_valid <= 1'b1;
        sec_valid  <= 1'b1;
        prim_data  <= p;
        sec_data   <= s;
        @(posedge pclk);
        prim_valid <= 1'b0;
        sec_valid  <= 1'b0;
        rd_chk(ADCRC_IDX_PRIM_HIGH, e[15:8], "prim high");
        rd_chk(ADCRC_IDX_PRIM_LOW, e[7:0], "prim low");
        rd_chk(ADCRC_IDX_SEC_HIGH, s[15:8], "sec high");
        rd_chk(ADCRC_IDX_SEC_LOW, s[7:0], "sec low");
    endtask : check_res

    // ********************************************************
    // main sequence
    // ********************************************************
    initial
    begin
        logic [15:0] cs [4];
        logic [9:0]  idx;
        logic [7:0]  d;
        cs = '{16'h0000, 16'h8000, 16'hFFFF, 16'h7FFF};
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {prim_valid, sec_valid, prim_data, sec_data} = '0;
        {cal_done_first, cal_done_sec} = '0;
        n_mismatch   = 0;
        total_checks = 0;
        presetn      = 1'b0;
        void'($urandom(32'hDAA6));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values
        rd_chk(ADCRC_IDX_CAL_PTR, 8'hD7, "ptr reset");
        rd_chk(ADCRC_IDX_REF_FIRST, 8'h00, "ref1 reset");
        rd_chk(ADCRC_IDX_REF_SEC, 8'h00, "ref2 reset");
        rd_chk(ADCRC_IDX_CFG_FIRST, 8'h00, "cfg1 reset");
        $display("test reset done");
        // bias and reference enables, reserved bits read zero
        apb(1'b1, ADCRC_IDX_REF_FIRST, 8'hFF);
        apb(1'b1, ADCRC_IDX_REF_SEC, 8'h02);
        rd_chk(ADCRC_IDX_REF_FIRST, 8'h03, "ref1");
        rd_chk(ADCRC_IDX_REF_SEC, 8'h02, "ref2");
        chk(32'({bias_gen_on_first, ref_buffer_on_first,
                 bias_gen_on_second, ref_buffer_on_second}),
            32'h0000000E, "enable pins");
        $display("test enables done");
        // single-ended then differential, corners first
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, ADCRC_IDX_CFG_FIRST, m ? 8'h10 : 8'h00);
            chk(32'(diff_mode), 32'(m), "diff mode");
            for (int i = 0; i < 8; i++)
                check_res(i < 4 ? cs[i] : 16'($urandom),
                          i < 4 ? 16'h0000 : 16'($urandom), 1'(m));
            check_res(16'h0002, 16'h0000, 1'(m));
        end
        apb(1'b1, ADCRC_IDX_CFG_FIRST, 8'h00);
        // result registers ignore writes without error
        apb(1'b1, ADCRC_IDX_SEC_LOW, 8'h55);
        chk(32'(er), 32'h0, "ro write err");
        rd_chk(ADCRC_IDX_SEC_LOW, 8'h00, "ro kept");
        $display("test results done");
        // each start bit per converter, cleared by finish pulse
        for (int c = 0; c < 2; c++)
            for (int b = 0; b < 3; b++)
            begin
                idx = c ? ADCRC_IDX_CFG_SEC : ADCRC_IDX_CFG_FIRST;
                apb(1'b1, idx, 8'h08 | (8'h01 << b));
                @(negedge pclk);
                chk(32'(c ? cal_run_sec : cal_run_first), 32'h1 << b,
                    "run set");
                chk(32'(c ? cal_run_first : cal_run_sec), 32'h0,
                    "other idle");
                chk(32'(c ? cal_src_sec : cal_src_first), 32'h1,
                    "src one");
                @(posedge pclk);
                if (c)
                    cal_done_sec <= 3'h1 << b;
                else
                    cal_done_first <= 3'h1 << b;
                @(posedge pclk);
                cal_done_first <= 3'h0;
                cal_done_sec   <= 3'h0;
                @(negedge pclk);
                chk(32'({cal_run_first, cal_run_sec}), 32'h0,
                    "run clear");
                apb(1'b1, idx, 8'h00);
                chk(32'(c ? cal_src_sec : cal_src_first), 32'h0,
                    "src zero");
            end
        $display("test calibration done");
        // fill both banks through the port, then read them back
        for (int w = 0; w < 2; w++)
            for (int b = 0; b < 2; b++)
            begin
                apb(1'b1, ADCRC_IDX_CAL_PTR, {1'b1, 1'(b), 6'h00});
                for (int i = 0; i < 24; i++)
                    if (w == 0)
                    begin
                        d = (i == 20 || i == 22) ? 8'hFF : 8'($urandom);
                        cexp[b][i] = d & keep(6'(i));
                        apb(1'b1, ADCRC_IDX_CAL_PORT, d);
                    end
                    else
                        rd_chk(ADCRC_IDX_CAL_PORT, cexp[b][i],
                               "coef");
                rd_chk(ADCRC_IDX_CAL_PTR, {1'b1, 1'(b), 6'h18},
                       "ptr inc");
            end
        chk(32'(offset_first), 32'({cexp[0][20][5:0], cexp[0][19]}),
            "offset1");
        chk(32'(gain_first), 32'({cexp[0][22][4:0], cexp[0][21]}),
            "gain1");
        chk(32'(offset_second), 32'({cexp[1][20][5:0], cexp[1][19]}),
            "offset2");
        chk(32'(gain_second), 32'({cexp[1][22][4:0], cexp[1][21]}),
            "gain2");
        // pointer stays put without auto-increment
        apb(1'b1, ADCRC_IDX_CAL_PTR, 8'h13);
        rd_chk(ADCRC_IDX_CAL_PORT, cexp[0][19], "no inc a");
        rd_chk(ADCRC_IDX_CAL_PORT, cexp[0][19], "no inc b");
        rd_chk(ADCRC_IDX_CAL_PTR, 8'h13, "ptr kept");
        $display("test coefficients done");
        // unmapped places answer with an error
        apb(1'b0, 10'h0D0, 8'h00);
        chk({rd[30:0], er}, 32'h1, "unmapped read");
        apb(1'b1, 10'h3FF, 8'hFF);
        chk(32'(er), 32'h1, "unmapped write");
        $display("test unmapped done");
        end_sim;
    end
endmodule : tb
`default_nettype wire
